// ### shared/irq_ctrl_pkg.sv
// package: constants, states and carriers of the interrupt control unit
package irq_ctrl_pkg;

  // -------------------------------------------------------------------------
  // special-function register addresses
  // -------------------------------------------------------------------------
  localparam logic [7:0] ADDR_ENABLE_EXT = 8'h2C;
  localparam logic [7:0] ADDR_PENDING_EXT = 8'h2E;
  localparam logic [7:0] ADDR_ENABLE_LOW = 8'h3A;
  localparam logic [7:0] ADDR_ENABLE_HIGH = 8'h3B;
  localparam logic [7:0] ADDR_PENDING_LOW = 8'h3C;
  localparam logic [7:0] ADDR_PENDING_HIGH = 8'h3D;

  // -------------------------------------------------------------------------
  // source map
  // -------------------------------------------------------------------------
  localparam int NUM_SRC = 24;
  localparam logic [23:0] LATCH_IMPL_MASK = 24'h0FFFFC;
  localparam logic [23:0] MASKABLE_MASK = 24'hFFFFF0;
  localparam logic [23:0] NONMASKABLE_MASK = 24'h00000C;
  localparam logic [23:0] ENABLE_IMPL_MASK = 24'hFFFFF1;
  localparam logic [23:0] LATCH_RESET = 24'h000000;
  localparam logic [23:0] ENABLE_RESET = 24'h000000;
  localparam int GLOBAL_FLAG_BIT = 0;
  localparam int TRAP_SRC = 2;
  localparam int WATCHDOG_SRC = 3;
  localparam int FIRST_MASKABLE = 4;
  localparam int SECOND_BANK = 16;
  localparam int STATUS_FLAG_BIT = 0;

  // -------------------------------------------------------------------------
  // vector table addresses
  // -------------------------------------------------------------------------
  localparam logic [15:0] VEC_SOFT_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_ADDR_TRAP = 16'hFFFA;
  localparam logic [15:0] VEC_WATCHDOG = 16'hFFF8;
  localparam logic [15:0] VEC_BANK0_TOP = 16'hFFF6;
  localparam logic [15:0] VEC_BANK1_TOP = 16'hFFBE;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int CLK_PER_MCYCLE = 4;
  localparam logic [1:0] MCYCLE_LAST_DIV = 2'(CLK_PER_MCYCLE - 1);
  localparam int ACCEPT_MCYCLES = 8;
  localparam logic [2:0] SEQ_LAST = 3'(ACCEPT_MCYCLES - 1);
  localparam logic [2:0] SEQ_STEP1 = 3'h1;
  localparam logic [2:0] SEQ_STEP2 = 3'h2;
  localparam logic [2:0] SEQ_STEP3 = 3'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCEPT = 2'b01,
    ST_RETURN = 2'b10
  } seq_state_e;

  // processor events, one-cycle pulses
  typedef struct packed {
    logic instr_last;
    logic enable_all_op;
    logic disable_all_op;
    logic software_trap_op;
    logic undefined_opcode_trap;
    logic maskable_return_op;
    logic nonmaskable_return_op;
  } cpu_ops_s;

  // stack port toward the processor
  typedef struct packed {
    logic push;
    logic pop;
    logic [7:0] data;
  } stack_s;

endpackage : irq_ctrl_pkg

// ### verilog/mcu_interrupt_control.sv
// interrupt control unit: pending latches, enable flags, accept and return sequences
// Operation
// - sources 2 to 19 have a latch set by their request; sources 0, 1 and 20 to 23 have none
// - a source latch clears the moment its interrupt is accepted
// - all pending latches are zero while reset is applied
// - software clears latches by writing zero; reads show latch state
// - writing one to a latch bit never sets it
// - non-maskable sources are accepted whatever the enable register holds
// - enable register spans three addresses, readable, writable, modify-safe
// - global flag zero blocks all maskable sources; one lets enabled through
// - acceptance stacks the global flag then clears it
// - return reloads the global flag from the stacked value
// - global flag is low enable bit zero, set/cleared by ops, resets zero
// - each source enable flag gates its source and resets to zero
// - a pending request stays until accepted, reset or cleared
// - acceptance takes eight machine cycles after the current instruction
// - acceptance pushes status, pc high, pc low then loads the vector
// - latch-to-acceptance delay stays within thirty-eight clock periods
// - maskable service ends with one return op, non-maskable with other
// - higher maskable requests wait until the global flag is set again
// - simultaneous requests are taken in fixed hardware priority order
// - return pops pc and status and raises the stack pointer by three
// - requests are sampled in each instruction's final cycle
`timescale 1ns/1ps

module mcu_interrupt_control (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic [23:0] i_irq_req,
  input wire irq_ctrl_pkg::cpu_ops_s i_cpu_ops,
  input wire logic [7:0] i_status_word,
  input wire logic [15:0] i_pc,
  input wire logic [7:0] i_stack_rdata,
  output irq_ctrl_pkg::stack_s o_stack,
  output logic o_busy,
  output logic o_vector_load,
  output logic [15:0] o_vector_addr,
  output logic o_nonmaskable_active,
  output logic o_restore,
  output logic [15:0] o_restore_pc,
  output logic [7:0] o_restore_status,
  output logic [23:0] o_pending,
  output logic o_global_enable
);

  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  function automatic logic [15:0] vector_of(input logic [4:0] src);
    logic [15:0] v;
    v = irq_ctrl_pkg::VEC_SOFT_TRAP;
    if (src == 5'(irq_ctrl_pkg::TRAP_SRC))
      v = irq_ctrl_pkg::VEC_ADDR_TRAP;
    else if (src == 5'(irq_ctrl_pkg::WATCHDOG_SRC))
      v = irq_ctrl_pkg::VEC_WATCHDOG;
    else if (src >= 5'(irq_ctrl_pkg::SECOND_BANK))
      v = irq_ctrl_pkg::VEC_BANK1_TOP
        - {10'h000, src - 5'(irq_ctrl_pkg::SECOND_BANK), 1'b0};
    else if (src >= 5'(irq_ctrl_pkg::FIRST_MASKABLE))
      v = irq_ctrl_pkg::VEC_BANK0_TOP
        - {10'h000, src - 5'(irq_ctrl_pkg::FIRST_MASKABLE), 1'b0};
    return v;
  endfunction : vector_of

  // lowest index wins: that is the fixed hardware order
  function automatic logic [4:0] first_set(input logic [23:0] vec);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (vec[i])
        idx = 5'(i);
    end
    return idx;
  endfunction : first_set

  // byte lane of a 24-bit register selected by an address triple
  function automatic logic [1:0] lane_of(input logic [7:0] addr, input logic [7:0] lo,
                                         input logic [7:0] hi, input logic [7:0] ext);
    logic [1:0] lane;
    lane = 2'h3;
    if (addr == lo)
      lane = 2'h0;
    else if (addr == hi)
      lane = 2'h1;
    else if (addr == ext)
      lane = 2'h2;
    return lane;
  endfunction : lane_of

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [23:0] pending_latch;
    logic [23:0] enable_register;
    irq_ctrl_pkg::seq_state_e state;
    logic [1:0] div;
    logic [2:0] seq;
    logic [4:0] src;
    logic nonmaskable;
    logic [7:0] saved_status;
    logic [15:0] saved_pc;
    logic [7:0] rdata;
    irq_ctrl_pkg::stack_s stack;
    logic vector_load;
    logic [15:0] vector_addr;
    logic restore;
    logic [15:0] restore_pc;
    logic [7:0] restore_status;
  } ctrl_s;

  ctrl_s st_ff;
  ctrl_s nxt_st;

  logic mcycle_en;
  logic [23:0] routed;
  logic [23:0] write_keep;
  logic [23:0] ack_clear;
  logic [1:0] pend_lane;
  logic [1:0] en_lane;
  logic soft_trap;
  logic take_accept;
  logic take_return;
  logic [4:0] accept_idx;

  assign mcycle_en = (st_ff.div == irq_ctrl_pkg::MCYCLE_LAST_DIV);
  assign pend_lane = lane_of(i_sfr_addr, irq_ctrl_pkg::ADDR_PENDING_LOW,
                             irq_ctrl_pkg::ADDR_PENDING_HIGH, irq_ctrl_pkg::ADDR_PENDING_EXT);
  assign en_lane = lane_of(i_sfr_addr, irq_ctrl_pkg::ADDR_ENABLE_LOW,
                           irq_ctrl_pkg::ADDR_ENABLE_HIGH, irq_ctrl_pkg::ADDR_ENABLE_EXT);
  assign soft_trap = i_cpu_ops.software_trap_op | i_cpu_ops.undefined_opcode_trap;

  // non-maskable latches bypass all gating
  always_comb
  begin
    routed = st_ff.pending_latch & irq_ctrl_pkg::NONMASKABLE_MASK;
    if (st_ff.enable_register[irq_ctrl_pkg::GLOBAL_FLAG_BIT])
      routed = routed | (st_ff.pending_latch & st_ff.enable_register
                         & irq_ctrl_pkg::MASKABLE_MASK);
  end

  // -------------------------------------------------------------------------
  // acceptance decision
  // -------------------------------------------------------------------------
  // trap ops come with the last cycle of their own instruction, so they are
  // judged on the same strobe as the latches and need no latch of their own
  assign take_accept = (st_ff.state == irq_ctrl_pkg::ST_IDLE) && i_cpu_ops.instr_last
                       && (soft_trap || routed != 24'h000000);
  // acceptance wins over a return offered in the same cycle
  assign take_return = (st_ff.state == irq_ctrl_pkg::ST_IDLE) && !take_accept
                       && (i_cpu_ops.maskable_return_op || i_cpu_ops.nonmaskable_return_op);
  // one encoder serves both the source record and the latch clear
  assign accept_idx = soft_trap ? 5'h00 : first_set(routed);

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    write_keep = {24{1'b1}};
    ack_clear = 24'h000000;
    nxt_st.div = mcycle_en ? 2'h0 : st_ff.div + 2'h1;
    nxt_st.stack.push = 1'b0;
    nxt_st.stack.pop = 1'b0;
    nxt_st.vector_load = 1'b0;
    nxt_st.restore = 1'b0;

    // register reads
    nxt_st.rdata = 8'h00;
    if (i_sfr_rd)
    begin
      if (pend_lane != 2'h3)
        nxt_st.rdata = st_ff.pending_latch[pend_lane * 8 +: 8];
      else if (en_lane != 2'h3)
        nxt_st.rdata = st_ff.enable_register[en_lane * 8 +: 8];
    end

    // enable register writes; read-modify-write is a read then a write
    if (i_sfr_wr && en_lane != 2'h3)
      nxt_st.enable_register[en_lane * 8 +: 8] = i_sfr_wdata;
    if (i_cpu_ops.enable_all_op)
      nxt_st.enable_register[irq_ctrl_pkg::GLOBAL_FLAG_BIT] = 1'b1;
    if (i_cpu_ops.disable_all_op)
      nxt_st.enable_register[irq_ctrl_pkg::GLOBAL_FLAG_BIT] = 1'b0;

    // latch writes only clear; a one keeps the bit as it is
    if (i_sfr_wr && pend_lane != 2'h3)
      write_keep[pend_lane * 8 +: 8] = i_sfr_wdata;

    // limitation: a trap op or return op offered while a sequence runs is
    // dropped, not queued; the core holds its next instruction until o_busy
    // falls, which is what keeps the stack order intact
    unique case (st_ff.state)
      irq_ctrl_pkg::ST_IDLE:
      begin
        // sampled only in an instruction's last cycle
        if (take_accept)
        begin
          nxt_st.state = irq_ctrl_pkg::ST_ACCEPT;
          nxt_st.seq = 3'h0;
          nxt_st.nonmaskable = soft_trap || ((routed & irq_ctrl_pkg::NONMASKABLE_MASK) != 24'h0);
          nxt_st.src = accept_idx;
          if (!soft_trap)
            ack_clear[accept_idx] = 1'b1;
          // flag goes onto the stack, then drops
          nxt_st.saved_status = i_status_word;
          nxt_st.saved_status[irq_ctrl_pkg::STATUS_FLAG_BIT] =
            st_ff.enable_register[irq_ctrl_pkg::GLOBAL_FLAG_BIT];
          nxt_st.enable_register[irq_ctrl_pkg::GLOBAL_FLAG_BIT] = 1'b0;
          nxt_st.saved_pc = i_pc;
          nxt_st.div = 2'h0;
        end
        else if (take_return)
        begin
          nxt_st.state = irq_ctrl_pkg::ST_RETURN;
          nxt_st.seq = 3'h0;
          nxt_st.div = 2'h0;
        end
      end

      irq_ctrl_pkg::ST_ACCEPT:
      begin
        if (mcycle_en)
        begin
          nxt_st.seq = st_ff.seq + 3'h1;
          // each push moves the stack pointer down one byte, three in all
          unique case (st_ff.seq)
            3'h0:
            begin
              nxt_st.stack.push = 1'b1;
              nxt_st.stack.data = st_ff.saved_status;
            end
            irq_ctrl_pkg::SEQ_STEP1:
            begin
              nxt_st.stack.push = 1'b1;
              nxt_st.stack.data = st_ff.saved_pc[15:8];
            end
            irq_ctrl_pkg::SEQ_STEP2:
            begin
              nxt_st.stack.push = 1'b1;
              nxt_st.stack.data = st_ff.saved_pc[7:0];
            end
            irq_ctrl_pkg::SEQ_LAST:
            begin
              nxt_st.vector_load = 1'b1;
              nxt_st.vector_addr = vector_of(st_ff.src);
              nxt_st.state = irq_ctrl_pkg::ST_IDLE;
            end
            default:
            begin
              nxt_st.stack.push = 1'b0;
            end
          endcase
        end
      end

      irq_ctrl_pkg::ST_RETURN:
      begin
        // popped byte is presented in the cycle the pop is shown
        // pops come back as pc low, pc high, then status
        if (st_ff.stack.pop)
        begin
          unique case (st_ff.seq)
            irq_ctrl_pkg::SEQ_STEP1:
              nxt_st.restore_pc[7:0] = i_stack_rdata;
            irq_ctrl_pkg::SEQ_STEP2:
              nxt_st.restore_pc[15:8] = i_stack_rdata;
            default:
            begin
              nxt_st.restore_status = i_stack_rdata;
              nxt_st.enable_register[irq_ctrl_pkg::GLOBAL_FLAG_BIT] =
                i_stack_rdata[irq_ctrl_pkg::STATUS_FLAG_BIT];
              nxt_st.restore = 1'b1;
              nxt_st.state = irq_ctrl_pkg::ST_IDLE;
            end
          endcase
        end
        else if (mcycle_en)
        begin
          nxt_st.seq = st_ff.seq + 3'h1;
          nxt_st.stack.pop = 1'b1;
        end
      end

      default:
      begin
        nxt_st.state = irq_ctrl_pkg::ST_IDLE;
      end
    endcase

    // hardware set wins over any clear in the same cycle
    nxt_st.pending_latch = ((st_ff.pending_latch & write_keep & ~ack_clear)
                            | i_irq_req) & irq_ctrl_pkg::LATCH_IMPL_MASK;
    nxt_st.enable_register = nxt_st.enable_register & irq_ctrl_pkg::ENABLE_IMPL_MASK;
  end

  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_ff <= '0;
      st_ff.pending_latch <= irq_ctrl_pkg::LATCH_RESET;
      st_ff.enable_register <= irq_ctrl_pkg::ENABLE_RESET;
      st_ff.state <= irq_ctrl_pkg::ST_IDLE;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  assign o_sfr_rdata = st_ff.rdata;
  assign o_stack = st_ff.stack;
  assign o_busy = (st_ff.state != irq_ctrl_pkg::ST_IDLE);
  assign o_vector_load = st_ff.vector_load;
  assign o_vector_addr = st_ff.vector_addr;
  assign o_nonmaskable_active = st_ff.nonmaskable;
  assign o_restore = st_ff.restore;
  assign o_restore_pc = st_ff.restore_pc;
  assign o_restore_status = st_ff.restore_status;
  assign o_pending = st_ff.pending_latch;
  assign o_global_enable = st_ff.enable_register[irq_ctrl_pkg::GLOBAL_FLAG_BIT];

endmodule : mcu_interrupt_control

// ### dv/irq_ctrl_monitor.sv
// checker: sequence and latch relations of the interrupt control unit
`timescale 1ns/1ps
module irq_ctrl_monitor (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic [23:0] i_irq_req,
  input wire irq_ctrl_pkg::cpu_ops_s i_cpu_ops,
  input wire logic [15:0] i_pc,
  input wire irq_ctrl_pkg::stack_s o_stack,
  input wire logic o_busy,
  input wire logic o_vector_load,
  input wire logic o_restore,
  input wire logic [7:0] o_restore_status,
  input wire logic [23:0] o_pending,
  input wire logic o_global_enable
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  logic idle_sample;
  logic no_op;
  assign idle_sample = !o_busy && i_cpu_ops.instr_last;
  assign no_op = !i_cpu_ops.software_trap_op && !i_cpu_ops.undefined_opcode_trap;
  // strobes are registered, so the first push is seen four edges after busy
  sequence accept_s;
    $rose(o_busy) ##4 o_stack.push;
  endsequence
  sequence return_s;
    $rose(o_busy) ##4 o_stack.pop;
  endsequence
  latch_cause_a: assert property (
    (o_pending & ~$past(o_pending) & ~$past(i_irq_req)) == 24'h0)
    else $error("latch rose without a request");
  latch_impl_a: assert property (
    (o_pending & ~irq_ctrl_pkg::LATCH_IMPL_MASK) == 24'h0)
    else $error("latch outside implemented sources");
  nmi_accept_a: assert property (
    idle_sample && |(o_pending & irq_ctrl_pkg::NONMASKABLE_MASK)
      |-> ##1 o_busy && !o_global_enable)
    else $error("non-maskable latch not accepted");
  mask_block_a: assert property (
    idle_sample && no_op && !o_global_enable && o_pending[3:2] == 2'h0
      && !i_cpu_ops.maskable_return_op && !i_cpu_ops.nonmaskable_return_op |-> ##1 !o_busy)
    else $error("maskable accepted with global flag clear");
  latch_clear_a: assert property (
    idle_sample && no_op && o_pending[2] && !i_irq_req[2] |-> ##1 !o_pending[2])
    else $error("accepted latch not cleared");
  accept_seq_a: assert property (
    accept_s |-> ##4 o_stack.push ##4 o_stack.push ##20 o_vector_load ##1 !o_busy)
    else $error("acceptance sequence timing wrong");
  push_flag_a: assert property (
    accept_s |-> o_stack.data[irq_ctrl_pkg::STATUS_FLAG_BIT] == $past(o_global_enable, 5))
    else $error("stacked flag differs");
  push_pch_a: assert property (
    accept_s ##4 o_stack.push |-> o_stack.data == $past(i_pc[15:8], 9))
    else $error("second push is not pc high byte");
  return_seq_a: assert property (
    return_s |-> ##4 o_stack.pop ##4 o_stack.pop ##1 o_restore && !o_busy)
    else $error("return sequence timing wrong");
  restore_flag_a: assert property (
    o_restore |-> o_global_enable == o_restore_status[0])
    else $error("global flag not reloaded");
  rdata_idle_a: assert property (!$past(i_sfr_rd) |-> o_sfr_rdata == 8'h00)
    else $error("read data outside a read");
  cover property (accept_s);
  cover property (return_s);
  cover property (idle_sample && o_global_enable && |o_pending[19:4]);
endmodule : irq_ctrl_monitor

// ### dv/core_stack_model.sv
// processor stack model answering the unit's push and pop strobes
`timescale 1ns/1ps
module core_stack_model (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire irq_ctrl_pkg::stack_s i_stack,
  output logic [7:0] o_rdata,
  output logic [7:0] o_sp
);
  logic [7:0] mem_ff [256];
  logic [7:0] sp_ff;
  logic [7:0] cnt_ff;
  // outside a pop the byte is a moving pattern, never the last value
  assign o_rdata = i_stack.pop ? mem_ff[sp_ff + 8'h01] : cnt_ff;
  assign o_sp = sp_ff;
  always_ff @(posedge i_ref_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      sp_ff <= 8'hFF;
      cnt_ff <= 8'h00;
    end
    else
    begin
      cnt_ff <= cnt_ff + 8'h01;
      if (i_stack.push)
      begin
        mem_ff[sp_ff] <= i_stack.data;
        sp_ff <= sp_ff - 8'h01;
      end
      else if (i_stack.pop)
        sp_ff <= sp_ff + 8'h01;
    end
endmodule : core_stack_model

// ### dv/tb.sv
// testbench: register access, acceptance and return of the interrupt unit
`timescale 1ns/1ps
module tb;
  localparam logic [6:0] LAST = 7'h40;
  localparam logic [6:0] EN = 7'h20;
  localparam logic [6:0] DIS = 7'h10;
  localparam logic [6:0] SWT = 7'h48;
  localparam logic [6:0] UND = 7'h44;
  localparam logic [6:0] MRET = 7'h02;
  localparam logic [6:0] NRET = 7'h01;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic [23:0] i_irq_req = 24'h0;
  irq_ctrl_pkg::cpu_ops_s i_cpu_ops = '0;
  logic [7:0] i_status_word = 8'hA4;
  logic [15:0] i_pc = 16'h1234;
  logic [7:0] i_stack_rdata;
  logic [7:0] o_sfr_rdata;
  irq_ctrl_pkg::stack_s o_stack;
  logic o_busy;
  logic o_vector_load;
  logic [15:0] o_vector_addr;
  logic o_nonmaskable_active;
  logic o_restore;
  logic [15:0] o_restore_pc;
  logic [7:0] o_restore_status;
  logic [23:0] o_pending;
  logic o_global_enable;
  logic [7:0] sp;
  logic saved_flag;
  int bad_count = 0;
  int num_checks = 0;
  mcu_interrupt_control dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_irq_req(i_irq_req), .i_cpu_ops(i_cpu_ops),
    .i_status_word(i_status_word), .i_pc(i_pc), .i_stack_rdata(i_stack_rdata),
    .o_stack(o_stack), .o_busy(o_busy), .o_vector_load(o_vector_load),
    .o_vector_addr(o_vector_addr), .o_nonmaskable_active(o_nonmaskable_active),
    .o_restore(o_restore), .o_restore_pc(o_restore_pc), .o_restore_status(o_restore_status),
    .o_pending(o_pending), .o_global_enable(o_global_enable));
  core_stack_model core (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_stack(o_stack),
    .o_rdata(i_stack_rdata), .o_sp(sp));
  always #4 i_ref_clk = ~i_ref_clk;
  // -------------------------------------------------------------------------
  // drivers and comparison
  // -------------------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic sfr(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_ref_clk);
    i_sfr_addr = addr;
    i_sfr_wdata = data;
    i_sfr_wr = wr;
    i_sfr_rd = !wr;
    @(negedge i_ref_clk);
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
  endtask : sfr
  task automatic op(input logic [6:0] ops, input logic [23:0] req);
    @(negedge i_ref_clk);
    i_cpu_ops = irq_ctrl_pkg::cpu_ops_s'(ops);
    i_irq_req = req;
    @(negedge i_ref_clk);
    i_cpu_ops = '0;
    i_irq_req = 24'h0;
  endtask : op
  task automatic accept(input logic [6:0] ops, input logic [15:0] vec, input logic nmi);
    saved_flag = o_global_enable;
    op(ops, 24'h0);
    chk("flag cleared", 24'h0, {23'h0, o_global_enable});
    for (int i = 0; i < 40 && o_vector_load !== 1'b1; i++) @(negedge i_ref_clk);
    chk("vector pulse", 24'h1, {23'h0, o_vector_load});
    chk("vector", {8'h0, vec}, {8'h0, o_vector_addr});
    chk("nonmaskable", {23'h0, nmi}, {23'h0, o_nonmaskable_active});
    chk("pushed sp", 24'hFC, {16'h0, sp});
    @(negedge i_ref_clk);
  endtask : accept
  task automatic ret(input logic [6:0] rop);
    op(rop, 24'h0);
    for (int i = 0; i < 20 && o_restore !== 1'b1; i++) @(negedge i_ref_clk);
    chk("restore pulse", 24'h1, {23'h0, o_restore});
    chk("restore pc", {8'h0, i_pc}, {8'h0, o_restore_pc});
    chk("restore status", {16'h0, i_status_word[7:1], saved_flag},
      {16'h0, o_restore_status});
    chk("flag back", {23'h0, saved_flag}, {23'h0, o_global_enable});
    chk("popped sp", 24'hFF, {16'h0, sp});
  endtask : ret
  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] addrs [7] = '{8'h3A, 8'h3B, 8'h2C, 8'h3C, 8'h3D, 8'h2E, 8'h3E};
    foreach (addrs[i])
    begin
      sfr(1'b0, addrs[i], 8'h00);
      chk("reset read", 24'h0, {16'h0, o_sfr_rdata});
    end
    chk("reset flag", 24'h0, {23'h0, o_global_enable});
    $display("test reset done");
  endtask : t_reset
  task automatic t_latch;
    op(7'h00, 24'hFFFFFF);
    chk("latched", irq_ctrl_pkg::LATCH_IMPL_MASK, o_pending);
    sfr(1'b0, 8'h3C, 8'h00);
    chk("read low", 24'hFC, {16'h0, o_sfr_rdata});
    sfr(1'b0, 8'h2E, 8'h00);
    chk("read ext", 24'h0F, {16'h0, o_sfr_rdata});
    sfr(1'b1, 8'h3C, 8'hFF);
    chk("one kept", irq_ctrl_pkg::LATCH_IMPL_MASK, o_pending);
    // trap and watchdog bits written as ones so they stay pending
    sfr(1'b1, 8'h3C, 8'h0C);
    sfr(1'b1, 8'h3D, 8'h00);
    sfr(1'b1, 8'h2E, 8'h00);
    chk("cleared", 24'h00000C, o_pending);
    $display("test latch done");
  endtask : t_latch
  task automatic t_nmi;
    accept(LAST, 16'hFFFA, 1'b1);
    chk("trap latch", 24'h000008, o_pending);
    ret(NRET);
    accept(LAST, 16'hFFF8, 1'b1);
    ret(NRET);
    accept(SWT, 16'hFFFC, 1'b1);
    ret(NRET);
    accept(UND, 16'hFFFC, 1'b1);
    ret(NRET);
    $display("test nonmaskable done");
  endtask : t_nmi
  task automatic t_mask;
    sfr(1'b1, 8'h3A, 8'h20);
    sfr(1'b1, 8'h3B, 8'h02);
    sfr(1'b1, 8'h2C, 8'h02);
    sfr(1'b0, 8'h2C, 8'h00);
    chk("enable ext", 24'h02, {16'h0, o_sfr_rdata});
    op(7'h00, 24'h020220);
    op(LAST, 24'h0);
    chk("blocked", 24'h0, {23'h0, o_busy});
    op(EN, 24'h0);
    sfr(1'b0, 8'h3A, 8'h00);
    chk("enable low", 24'h21, {16'h0, o_sfr_rdata});
    accept(LAST, 16'hFFF4, 1'b0);
    op(LAST, 24'h0);
    chk("no preempt", 24'h0, {23'h0, o_busy});
    ret(MRET);
    accept(LAST, 16'hFFEC, 1'b0);
    ret(MRET);
    accept(LAST, 16'hFFBC, 1'b0);
    ret(MRET);
    chk("all served", 24'h0, o_pending);
    op(DIS, 24'h0);
    chk("disabled", 24'h0, {23'h0, o_global_enable});
    $display("test maskable done");
  endtask : t_mask
  task automatic t_midreset;
    op(EN, 24'hFFFFFF);
    chk("latched again", irq_ctrl_pkg::LATCH_IMPL_MASK, o_pending);
    @(negedge i_ref_clk);
    i_resetn = 1'b0;
    @(negedge i_ref_clk);
    chk("reset latches", 24'h0, o_pending);
    chk("reset flag low", 24'h0, {23'h0, o_global_enable});
    chk("reset busy", 24'h0, {23'h0, o_busy});
    repeat (2) @(negedge i_ref_clk);
    i_resetn = 1'b1;
    sfr(1'b0, 8'h3B, 8'h00);
    chk("reset enables", 24'h0, {16'h0, o_sfr_rdata});
    $display("test mid reset done");
  endtask : t_midreset
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    close_out();
  end
  initial
  begin
    repeat (16) @(negedge i_ref_clk);
    i_resetn = 1'b1;
    t_reset();
    t_latch();
    t_nmi();
    t_mask();
    t_midreset();
    close_out();
  end
endmodule : tb
bind mcu_interrupt_control irq_ctrl_monitor mon (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
  .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata), .i_irq_req(i_irq_req),
  .i_cpu_ops(i_cpu_ops), .i_pc(i_pc), .o_stack(o_stack), .o_busy(o_busy),
  .o_vector_load(o_vector_load), .o_restore(o_restore), .o_restore_status(o_restore_status),
  .o_pending(o_pending), .o_global_enable(o_global_enable));
